// File: pwg_pkg.sv
// constants, register map and carrier types of the pwm output generator
package pwg_pkg;
   localparam logic [15:0] PWG_ADDR_WIDTH_HI = 16'hffbd;
   localparam logic [15:0] PWG_ADDR_WIDTH_LO = 16'hffbe;
   localparam logic [15:0] PWG_ADDR_RATE_CTL = 16'hffbf;
   localparam logic [7:0] PWG_RST_WIDTH_HI = 8'h00;
   localparam logic [7:0] PWG_RST_WIDTH_LO = 8'h00;
   localparam logic [7:0] PWG_RST_RATE_CTL = 8'h00;
   localparam int PWG_OUTPUT_ON_POS = 7;
   localparam int PWG_RATE_CODE_MSB = 6;
   localparam logic [15:0] PWG_WIDTH_FULL = 16'hffff;
   localparam logic [15:0] PWG_WIDTH_ZERO = 16'h0000;
   // 732.4 Hz times 65536 phase steps gives a 48 MHz base rate
   localparam int PWG_CLK_RATE_MHZ = 250;
   localparam int PWG_BASE_RATE_MHZ = 48;
   localparam logic [8:0] PWG_ACC_MOD = 9'(PWG_CLK_RATE_MHZ);
   localparam logic [8:0] PWG_ACC_INC = 9'(PWG_BASE_RATE_MHZ);

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } pwg_bus_req_t;

   typedef struct packed {
      logic [8:0] acc_ff;
      logic tick_ff;
   } pwg_tick_state_t;

   typedef struct packed {
      logic [7:0] rate_ctl_ff;
      logic [7:0] width_lo_ff;
      logic [7:0] width_hi_ff;
      logic [15:0] phase_ff;
      logic out_ff;
      logic [7:0] rdata_ff;
   } pwg_state_t;
endpackage

// File: pwg_tick_gen.sv
// fractional divider: 48 MHz base tick from the 250 MHz clock
`timescale 1ns/10ps
module pwg_tick_gen import pwg_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   output logic tick
);
   pwg_tick_state_t st_ff;
   pwg_tick_state_t nxt_st;

   always_comb begin
      logic [8:0] sum;
      sum = st_ff.acc_ff + PWG_ACC_INC;
      nxt_st = st_ff;
      if (sum >= PWG_ACC_MOD) begin
         nxt_st.acc_ff = sum - PWG_ACC_MOD;
         nxt_st.tick_ff = 1'b1;
      end else begin
         nxt_st.acc_ff = sum;
         nxt_st.tick_ff = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick = st_ff.tick_ff;

   chk_tick_spacing: assert property (@(posedge clk) disable iff (!nrst)
      tick |=> !tick)
      else $error("base tick asserted two cycles in a row");
   cov_tick: cover property (@(posedge clk) disable iff (!nrst) tick);
endmodule // pwg_tick_gen

// File: pwg_pwm_gen.sv
// pwm output generator with its three memory-mapped control registers
`timescale 1ns/10ps
module pwg_pwm_gen import pwg_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   input pwg_bus_req_t bus_req,
   output logic [7:0] rdata,
   output logic pwm_out
);
   pwg_state_t st_ff;
   pwg_state_t nxt_st;
   logic base_tick;

   // phase advance per base tick: code 0 -> 1 step, code 127 -> 128 steps
   function automatic logic [15:0] rate_step(input logic [7:0] ctl);
      rate_step = {9'h000, ctl[PWG_RATE_CODE_MSB:0]} + 16'h0001;
   endfunction

   function automatic logic duty_level(input logic [15:0] width,
                                       input logic [15:0] phase);
      duty_level = (width == PWG_WIDTH_FULL) || (phase < width);
   endfunction

   // the three addresses this block answers
   function automatic logic is_mapped(input logic [15:0] addr);
      is_mapped = (addr == PWG_ADDR_RATE_CTL) ||
         (addr == PWG_ADDR_WIDTH_LO) || (addr == PWG_ADDR_WIDTH_HI);
   endfunction

   // 48 of every 250 clocks carry one base tick, each advancing the phase by rate_step steps while the output is on
   pwg_tick_gen u_tick (
      .clk(clk),
      .nrst(nrst),
      .tick(base_tick)
   );

   logic output_on;
   logic [15:0] width_val;
   assign output_on = st_ff.rate_ctl_ff[PWG_OUTPUT_ON_POS];
   assign width_val = {st_ff.width_hi_ff, st_ff.width_lo_ff};

   always_comb begin
      nxt_st = st_ff;
      // register writes
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            PWG_ADDR_RATE_CTL: begin
               nxt_st.rate_ctl_ff = bus_req.wdata;
            end
            PWG_ADDR_WIDTH_LO: begin
               nxt_st.width_lo_ff = bus_req.wdata;
            end
            PWG_ADDR_WIDTH_HI: begin
               nxt_st.width_hi_ff = bus_req.wdata;
            end
            default: begin
            end
         endcase
      end
      // register reads, other addresses answer zero
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            PWG_ADDR_RATE_CTL: nxt_st.rdata_ff = st_ff.rate_ctl_ff;
            PWG_ADDR_WIDTH_LO: nxt_st.rdata_ff = st_ff.width_lo_ff;
            PWG_ADDR_WIDTH_HI: nxt_st.rdata_ff = st_ff.width_hi_ff;
            default: nxt_st.rdata_ff = 8'h00;
         endcase
      end
      // phase accumulator, held at zero while off
      if (!output_on) begin
         nxt_st.phase_ff = 16'h0000;
      end else if (base_tick) begin
         nxt_st.phase_ff = st_ff.phase_ff + rate_step(st_ff.rate_ctl_ff);
      end
      // output level
      nxt_st.out_ff = output_on &&
         duty_level(width_val, st_ff.phase_ff);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= '0;
         st_ff.rate_ctl_ff <= PWG_RST_RATE_CTL;
         st_ff.width_lo_ff <= PWG_RST_WIDTH_LO;
         st_ff.width_hi_ff <= PWG_RST_WIDTH_HI;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata = st_ff.rdata_ff;
   assign pwm_out = st_ff.out_ff;

   // enable, phase and rate control register
   chk_off_low: assert property (
      @(posedge clk) disable iff (!nrst)
      !output_on |=> !pwm_out)
      else $error("output high while disabled");
   chk_phase_held: assert property (
      @(posedge clk) disable iff (!nrst)
      !output_on |=> st_ff.phase_ff == 16'h0000)
      else $error("phase not held at zero while off");
   chk_enable_start: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(output_on) |-> st_ff.phase_ff == 16'h0000)
      else $error("period did not start from zero phase");
   chk_phase_step: assert property (
      @(posedge clk) disable iff (!nrst)
      (output_on && base_tick && !bus_req.wr) |=> st_ff.phase_ff ==
         16'($past(st_ff.phase_ff) + rate_step($past(st_ff.rate_ctl_ff))))
      else $error("phase did not advance by rate step");
   chk_phase_hold: assert property (
      @(posedge clk) disable iff (!nrst)
      (output_on && !base_tick) |=> $stable(st_ff.phase_ff))
      else $error("phase moved without a base tick");
   chk_rate_store: assert property (
      @(posedge clk) disable iff (!nrst)
      (bus_req.wr && bus_req.addr == PWG_ADDR_RATE_CTL) |=>
         st_ff.rate_ctl_ff == $past(bus_req.wdata))
      else $error("rate control byte not stored");
   chk_rate_read: assert property (
      @(posedge clk) disable iff (!nrst)
      (bus_req.rd && bus_req.addr == PWG_ADDR_RATE_CTL) |=>
         rdata == $past(st_ff.rate_ctl_ff))
      else $error("rate control byte read back wrong");

   // register bus
   chk_lo_write: assert property (
      @(posedge clk) disable iff (!nrst)
      (bus_req.wr && bus_req.addr == PWG_ADDR_WIDTH_LO) ##1
      (bus_req.rd && bus_req.addr == PWG_ADDR_WIDTH_LO && !bus_req.wr) |=>
         rdata == $past(bus_req.wdata, 2))
      else $error("low width byte read back wrong");
   chk_lo_store: assert property (
      @(posedge clk) disable iff (!nrst)
      (bus_req.wr && bus_req.addr == PWG_ADDR_WIDTH_LO) |=>
         st_ff.width_lo_ff == $past(bus_req.wdata))
      else $error("low width byte not stored");
   chk_lo_alone: assert property (
      @(posedge clk) disable iff (!nrst)
      (bus_req.wr && bus_req.addr == PWG_ADDR_WIDTH_LO) |=>
         $stable(st_ff.width_hi_ff))
      else $error("low byte write touched the high byte");
   chk_lo_read: assert property (
      @(posedge clk) disable iff (!nrst)
      (bus_req.rd && bus_req.addr == PWG_ADDR_WIDTH_LO) |=>
         rdata == $past(st_ff.width_lo_ff))
      else $error("low width byte read wrong");
   chk_hi_write: assert property (
      @(posedge clk) disable iff (!nrst)
      (bus_req.wr && bus_req.addr == PWG_ADDR_WIDTH_HI) |=>
         st_ff.width_hi_ff == $past(bus_req.wdata))
      else $error("high width byte not stored");
   chk_hi_rdback: assert property (
      @(posedge clk) disable iff (!nrst)
      (bus_req.wr && bus_req.addr == PWG_ADDR_WIDTH_HI) ##1
      (bus_req.rd && bus_req.addr == PWG_ADDR_WIDTH_HI && !bus_req.wr) |=>
         rdata == $past(bus_req.wdata, 2))
      else $error("high width byte read back wrong");
   chk_hi_read: assert property (
      @(posedge clk) disable iff (!nrst)
      (bus_req.rd && bus_req.addr == PWG_ADDR_WIDTH_HI) |=>
         rdata == $past(st_ff.width_hi_ff))
      else $error("high width byte read wrong");
   chk_rdata_hold: assert property (
      @(posedge clk) disable iff (!nrst)
      !bus_req.rd |=> $stable(rdata))
      else $error("read data changed without a read");
   chk_regs_quiet: assert property (
      @(posedge clk) disable iff (!nrst)
      !bus_req.wr |=> $stable({st_ff.rate_ctl_ff, st_ff.width_lo_ff,
         st_ff.width_hi_ff}))
      else $error("register changed without a write");
   chk_write_other: assert property (
      @(posedge clk) disable iff (!nrst)
      (bus_req.wr && !is_mapped(bus_req.addr)) |=> $stable(
         {st_ff.rate_ctl_ff, st_ff.width_lo_ff, st_ff.width_hi_ff}))
      else $error("unmapped write changed a register");
   chk_unmapped_zero: assert property (
      @(posedge clk) disable iff (!nrst)
      (bus_req.rd && !is_mapped(bus_req.addr)) |=>
         rdata == 8'h00)
      else $error("unmapped read not zero");

   // duty cycle
   chk_full_high: assert property (
      @(posedge clk) disable iff (!nrst)
      (output_on && width_val == PWG_WIDTH_FULL) |=> pwm_out)
      else $error("full width not high");
   chk_zero_low: assert property (
      @(posedge clk) disable iff (!nrst)
      (width_val == PWG_WIDTH_ZERO) |=> !pwm_out)
      else $error("zero width not low");
   chk_duty_cmp: assert property (
      @(posedge clk) disable iff (!nrst)
      (output_on && st_ff.phase_ff < width_val) |=> pwm_out)
      else $error("output low inside high time");
   chk_duty_low: assert property (
      @(posedge clk) disable iff (!nrst)
      (output_on && width_val != PWG_WIDTH_FULL &&
       st_ff.phase_ff >= width_val) |=> !pwm_out)
      else $error("output high inside low time");
   chk_enable_first: assert property (
      @(posedge clk) disable iff (!nrst)
      ($rose(output_on) && width_val != PWG_WIDTH_ZERO) |=>
         pwm_out)
      else $error("first period did not open high");

   cov_enable: cover property (@(posedge clk) disable iff (!nrst)
      $rose(output_on));
   cov_wrap: cover property (@(posedge clk) disable iff (!nrst)
      output_on && st_ff.phase_ff < $past(st_ff.phase_ff));
   cov_toggle: cover property (@(posedge clk) disable iff (!nrst)
      $rose(pwm_out) ##[1:1000] $fell(pwm_out));
   cov_back_to_back: cover property (@(posedge clk) disable iff (!nrst)
      bus_req.wr ##1 bus_req.rd);
endmodule // pwg_pwm_gen

// File: pwg_load.sv
// load model on the pwm pin: counts high cycles and rising edges
`timescale 1ns/10ps
module pwg_load (
   input wire logic clk,
   input wire logic clr,
   input wire logic pin,
   output int high_cnt,
   output int rise_cnt
);
   logic last_ff;
   always_ff @(posedge clk) begin
      last_ff <= pin;
      if (clr) begin
         high_cnt <= 0;
         rise_cnt <= 0;
      end else begin
         high_cnt <= high_cnt + int'(pin);
         rise_cnt <= rise_cnt + int'(pin & ~last_ff);
      end
   end
endmodule // pwg_load

// File: tb_pwg_pwm_gen.sv
// testbench of the pwm output generator
`timescale 1ns/10ps
module tb_pwg_pwm_gen;
   import pwg_pkg::*;
   logic clk, nrst, clr, pwm_out;
   logic [7:0] rdata;
   pwg_bus_req_t bus_req;
   int high_cnt, rise_cnt, num_errors, compares;
   pwg_pwm_gen i_dut (.clk(clk), .nrst(nrst), .bus_req(bus_req),
      .rdata(rdata), .pwm_out(pwm_out));
   pwg_load i_load (.clk(clk), .clr(clr), .pin(pwm_out),
      .high_cnt(high_cnt), .rise_cnt(rise_cnt));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic cmp_rng(string what, int lo, int hi, int got);
      compares++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("BAD %s exp %0d..%0d got %0d", what, lo, hi, got);
      end
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(posedge clk);
      #1;
      bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      #1;
      bus_req.wr = 1'b0;
   endtask
   task automatic rd(logic [15:0] a, logic [7:0] exp, string what);
      @(posedge clk);
      #1;
      bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      #1;
      bus_req.rd = 1'b0;
      cmp8(what, exp, rdata);
   endtask
   // write, then read the same address in the very next cycle
   task automatic wr_rd(logic [15:0] a, logic [7:0] d, string what);
      @(posedge clk);
      #1;
      bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      #1;
      bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      #1;
      bus_req.rd = 1'b0;
      cmp8(what, d, rdata);
   endtask
   // clear the load counters, then watch n cycles
   task automatic meas(int n);
      @(posedge clk);
      #1;
      clr = 1'b1;
      @(posedge clk);
      #1;
      clr = 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic end_of_test;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      bus_req = '0;
      clr = 1'b0;
      nrst = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      nrst = 1'b1;
      rd(PWG_ADDR_WIDTH_HI, PWG_RST_WIDTH_HI, "hi rst");
      rd(PWG_ADDR_WIDTH_LO, PWG_RST_WIDTH_LO, "lo rst");
      rd(PWG_ADDR_RATE_CTL, PWG_RST_RATE_CTL, "rate rst");
      rd(16'hffc0, 8'h00, "unmapped");
      wr_rd(PWG_ADDR_WIDTH_LO, 8'h3c, "lo b2b");
      wr_rd(PWG_ADDR_WIDTH_HI, 8'hc3, "hi b2b");
      wr(PWG_ADDR_WIDTH_LO, 8'ha5);
      wr(PWG_ADDR_WIDTH_HI, 8'h5a);
      wr(PWG_ADDR_RATE_CTL, 8'h7f);
      rd(PWG_ADDR_WIDTH_LO, 8'ha5, "lo");
      rd(PWG_ADDR_WIDTH_HI, 8'h5a, "hi");
      rd(PWG_ADDR_RATE_CTL, 8'h7f, "rate");
      wr(16'hffc0, 8'hff);
      rd(PWG_ADDR_RATE_CTL, 8'h7f, "rate kept");
      wr(PWG_ADDR_WIDTH_LO, 8'hff);
      wr(PWG_ADDR_WIDTH_HI, 8'hff);
      meas(3000);
      cmp_rng("off high", 0, 0, high_cnt);
      wr(PWG_ADDR_RATE_CTL, 8'hff);
      meas(3000);
      cmp_rng("full high", 3000, 3000, high_cnt);
      wr(PWG_ADDR_WIDTH_HI, 8'h00);
      wr(PWG_ADDR_WIDTH_LO, 8'h00);
      meas(3000);
      cmp_rng("zero high", 0, 0, high_cnt);
      wr(PWG_ADDR_WIDTH_HI, 8'h40);
      // code 7fh: period 2666.7 clocks, window of four periods
      meas(10667);
      cmp_rng("q high 7f", 2600, 2730, high_cnt);
      cmp_rng("rises 7f", 4, 5, rise_cnt);
      wr(PWG_ADDR_RATE_CTL, 8'hbf);
      meas(10667);
      cmp_rng("q high 3f", 2600, 2730, high_cnt);
      cmp_rng("rises 3f", 2, 3, rise_cnt);
      wr(PWG_ADDR_RATE_CTL, 8'h00);
      wr(PWG_ADDR_WIDTH_HI, 8'h01);
      wr(PWG_ADDR_RATE_CTL, 8'h80);
      // code 00h from off: one step per tick, 256 steps high
      meas(3000);
      cmp_rng("q high 00", 1320, 1340, high_cnt);
      cmp_rng("rises 00", 0, 0, rise_cnt);
      end_of_test();
   end
endmodule // tb_pwg_pwm_gen
